// File: rtl/spi_cmd_pkg.sv
// constants and types of the serial command front end
package spi_cmd_pkg;
	localparam int CLK_MHZ = 100;
	localparam int WRITE_CYCLE_TIME_MS = 5;
	localparam int POWERUP_DELAY_MS = 1;
	localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_TIME_MS * 1000 * 1000 * CLK_MHZ / 1000;
	localparam int POWERUP_CYCLES = POWERUP_DELAY_MS * 1000 * 1000 * CLK_MHZ / 1000;
	localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_SET_LATCH = 8'h06;
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_BP0 = 2;
	localparam int ST_BP1 = 3;
	localparam int ST_LOCK = 4;
	localparam int ST_IDSEL = 6;
	localparam int ST_PPEN = 7;
	localparam logic [7:0] ST_WRITABLE = 8'hdc;
	localparam logic [2:0] BITS_PER_BYTE = 3'h7;
	localparam logic [4:0] ADDR_BITS = 5'h10;
	localparam logic [6:0] ID_PAGE_MASK = 7'h7f;
	localparam int FIFO_DEPTH = 16;
	typedef enum logic [5:0]
	{
		PH_OPCODE = 6'h01,
		PH_ADDR = 6'h02,
		PH_WDATA = 6'h04,
		PH_RDATA = 6'h08,
		PH_STATUS = 6'h10,
		PH_IGNORE = 6'h20
	} phase_e;
endpackage

// File: rtl/spi_cmd_fifo.sv
// small synchronous fifo with valid and ready on both sides
module spi_cmd_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
	} state_s;
	logic [WIDTH-1:0] mem [DEPTH];
	state_s r;
	state_s next_r;
	logic push;
	logic pop;
	// one spare pointer bit tells full from empty
	assign o_ready = (r.wr_ptr - r.rd_ptr) != (AW+1)'(DEPTH);
	assign o_valid = r.wr_ptr != r.rd_ptr;
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	assign o_data = mem[r.rd_ptr[AW-1:0]];
	always_comb
	begin
		next_r = r;
		next_r.wr_ptr = r.wr_ptr + (AW+1)'(push);
		next_r.rd_ptr = r.rd_ptr + (AW+1)'(pop);
	end
	always_ff @(posedge i_clk)
	begin
		if (push)
		begin
			mem[r.wr_ptr[AW-1:0]] <= i_data;
		end
	end
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			r <= '0;
		end
		else
		begin
			r <= next_r;
		end
	end
endmodule

// File: rtl/spi_cmd_front_end.sv
// serial command decoder, status register and write-cycle timing
module spi_cmd_front_end #(
	parameter int WRITE_CYCLE_CYCLES = spi_cmd_pkg::WRITE_CYCLE_CYCLES,
	parameter int POWERUP_CYCLES = spi_cmd_pkg::POWERUP_CYCLES
) (
	input wire logic I_SYS_CLK,
	input wire logic I_RESET_N,
	input wire logic I_SCK,
	input wire logic I_CS_N,
	input wire logic I_SI,
	input wire logic I_HOLD_N,
	input wire logic I_WP_N,
	output logic O_SO,
	output logic O_SO_OE,
	output logic O_MEM_REQ_VALID,
	input wire logic I_MEM_REQ_READY,
	output logic O_MEM_REQ_WRITE,
	output logic O_MEM_REQ_ID_PAGE,
	output logic [15:0] O_MEM_REQ_ADDR,
	output logic [7:0] O_MEM_REQ_DATA,
	input wire logic [7:0] I_MEM_RDATA,
	output logic O_PROGRAM_START,
	output logic O_BUSY,
	output logic O_READY,
	output logic [7:0] O_STATUS
);
	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [1:0] sck_s;
		logic [1:0] cs_s;
		logic [1:0] si_s;
		logic [1:0] hold_s;
		logic [1:0] wp_s;
		logic sck_d;
		spi_cmd_pkg::phase_e phase;
		logic [7:0] shift;
		logic [2:0] bit_cnt;
		logic [4:0] addr_cnt;
		logic [7:0] opcode;
		logic [15:0] addr;
		logic [7:0] out_byte;
		logic so;
		logic so_oe;
		logic [7:0] status;
		logic wrote;
		logic pend_write;
		logic [31:0] timer;
		logic [31:0] pu_timer;
		logic program_start;
	} state_s;
	state_s r;
	state_s next_r;
	logic fifo_ready;
	logic [25:0] fifo_in;
	logic fifo_valid_in;
	logic [25:0] fifo_out;
	logic sck_rise;
	logic sck_fall;
	logic sel;
	logic active;
	logic [7:0] byte_in;
	logic status_locked;

	// ************************************************************
	// synchronised pins and serial clock edges
	// ************************************************************
	// edges come from the second sync flop only, so select, data and clock stay aligned
	assign sel = !r.cs_s[1];
	assign sck_rise = r.sck_s[1] && !r.sck_d;
	assign sck_fall = !r.sck_s[1] && r.sck_d;
	assign active = sel && r.hold_s[1];
	assign byte_in = {r.shift[6:0], r.si_s[1]};
	assign status_locked = !r.wp_s[1] && r.status[spi_cmd_pkg::ST_PPEN];

	// ************************************************************
	// next state
	// ************************************************************
	always_comb
	begin
		next_r = r;
		fifo_valid_in = 1'b0;
		fifo_in = {1'b1, r.status[spi_cmd_pkg::ST_IDSEL], r.addr, byte_in};
		next_r.program_start = 1'b0;
		// two-flop synchronisers for all pins
		next_r.sck_s = {r.sck_s[0], I_SCK};
		next_r.cs_s = {r.cs_s[0], I_CS_N};
		next_r.si_s = {r.si_s[0], I_SI};
		next_r.hold_s = {r.hold_s[0], I_HOLD_N};
		next_r.wp_s = {r.wp_s[0], I_WP_N};
		// edge memory runs on through a pause, so edges seen then are dropped
		next_r.sck_d = r.sck_s[1];
		if (r.pu_timer != '0)
		begin
			next_r.pu_timer = r.pu_timer - 32'd1;
		end
		if (r.timer != '0)
		begin
			next_r.timer = r.timer - 32'd1;
			if (r.timer == 32'd1)
			begin
				next_r.status[spi_cmd_pkg::ST_BUSY] = 1'b0;
				next_r.status[spi_cmd_pkg::ST_WEL] = 1'b0;
			end
		end
		if (!sel)
		begin
			next_r.so_oe = 1'b0;
			next_r.phase = spi_cmd_pkg::PH_OPCODE;
			next_r.bit_cnt = '0;
			next_r.addr_cnt = '0;
			if (r.pend_write)
			begin
				// internal cycle starts on deselect, timed from here
				next_r.pend_write = 1'b0;
				next_r.program_start = 1'b1;
				next_r.timer = 32'(WRITE_CYCLE_CYCLES);
				next_r.status[spi_cmd_pkg::ST_BUSY] = 1'b1;
				next_r.status[spi_cmd_pkg::ST_IDSEL] = 1'b0;
			end
			else if (r.wrote)
			begin
				next_r.status[spi_cmd_pkg::ST_IDSEL] = 1'b0;
			end
			next_r.wrote = 1'b0;
		end
		else if (!active)
		begin
			// paused: no edge is taken and the frame state holds; sync flops, edge memory and timers run on
			next_r.so_oe = r.so_oe;
		end
		else if (sck_rise && r.phase != spi_cmd_pkg::PH_IGNORE)
		begin
			next_r.so_oe = r.phase == spi_cmd_pkg::PH_RDATA || r.phase == spi_cmd_pkg::PH_STATUS;
			next_r.shift = byte_in;
			next_r.bit_cnt = r.bit_cnt + 3'd1;
			case (r.phase)
				spi_cmd_pkg::PH_OPCODE:
				begin
					if (r.bit_cnt == spi_cmd_pkg::BITS_PER_BYTE)
					begin
						next_r.opcode = byte_in;
						next_r.phase = spi_cmd_pkg::PH_IGNORE;
						next_r.so_oe = 1'b0;
						if (byte_in == spi_cmd_pkg::OP_READ_STATUS)
						begin
							next_r.phase = spi_cmd_pkg::PH_STATUS;
							next_r.out_byte = r.status;
						end
						else if (r.status[spi_cmd_pkg::ST_BUSY] || r.pu_timer != '0)
						begin
							next_r.phase = spi_cmd_pkg::PH_IGNORE;
						end
						else if (byte_in == spi_cmd_pkg::OP_SET_LATCH)
						begin
							next_r.status[spi_cmd_pkg::ST_WEL] = 1'b1;
						end
						else if (byte_in == spi_cmd_pkg::OP_CLEAR_LATCH)
						begin
							next_r.status[spi_cmd_pkg::ST_WEL] = 1'b0;
						end
						else if (byte_in == spi_cmd_pkg::OP_WRITE_STATUS)
						begin
							next_r.phase = spi_cmd_pkg::PH_WDATA;
						end
						else if (byte_in == spi_cmd_pkg::OP_READ || byte_in == spi_cmd_pkg::OP_WRITE)
						begin
							next_r.phase = spi_cmd_pkg::PH_ADDR;
						end
						// any other code stays in PH_IGNORE with output off
					end
				end
				spi_cmd_pkg::PH_ADDR:
				begin
					next_r.addr = {r.addr[14:0], r.si_s[1]};
					next_r.addr_cnt = r.addr_cnt + 5'd1;
					if (r.addr_cnt + 5'd1 == spi_cmd_pkg::ADDR_BITS)
					begin
						next_r.bit_cnt = '0;
						next_r.phase = r.opcode == spi_cmd_pkg::OP_READ ? spi_cmd_pkg::PH_RDATA
							: spi_cmd_pkg::PH_WDATA;
					end
				end
				spi_cmd_pkg::PH_WDATA:
				begin
					if (r.bit_cnt == spi_cmd_pkg::BITS_PER_BYTE)
					begin
						if (r.opcode == spi_cmd_pkg::OP_WRITE_STATUS)
						begin
							// both id bits set at once is refused: leave them as they are
							if (r.status[spi_cmd_pkg::ST_WEL] && !status_locked)
							begin
								next_r.status = (r.status & ~spi_cmd_pkg::ST_WRITABLE)
									| (byte_in & spi_cmd_pkg::ST_WRITABLE);
								next_r.status[spi_cmd_pkg::ST_LOCK] = r.status[spi_cmd_pkg::ST_LOCK]
									| byte_in[spi_cmd_pkg::ST_LOCK];
								if (byte_in[spi_cmd_pkg::ST_LOCK] && byte_in[spi_cmd_pkg::ST_IDSEL])
								begin
									next_r.status[spi_cmd_pkg::ST_LOCK] = r.status[spi_cmd_pkg::ST_LOCK];
									next_r.status[spi_cmd_pkg::ST_IDSEL] = r.status[spi_cmd_pkg::ST_IDSEL];
								end
								next_r.status[spi_cmd_pkg::ST_WEL] = 1'b0;
							end
							next_r.phase = spi_cmd_pkg::PH_IGNORE;
						end
						else if (r.status[spi_cmd_pkg::ST_WEL]
							&& !(r.status[spi_cmd_pkg::ST_IDSEL] && r.status[spi_cmd_pkg::ST_LOCK]))
						begin
							fifo_valid_in = fifo_ready;
							fifo_in[23:8] = r.status[spi_cmd_pkg::ST_IDSEL]
								? {9'h000, r.addr[6:0] & spi_cmd_pkg::ID_PAGE_MASK} : r.addr;
							next_r.pend_write = r.pend_write || fifo_ready;
							next_r.wrote = 1'b1;
							next_r.addr[6:0] = r.addr[6:0] + 7'd1;
						end
					end
				end
				spi_cmd_pkg::PH_RDATA:
				begin
					if (r.bit_cnt == spi_cmd_pkg::BITS_PER_BYTE)
					begin
						next_r.addr = r.addr + 16'd1;
						next_r.wrote = 1'b1;
					end
				end
				default:
				begin
				end
			endcase
		end
		else if (sck_fall && (r.phase == spi_cmd_pkg::PH_RDATA || r.phase == spi_cmd_pkg::PH_STATUS))
		begin
			next_r.so_oe = 1'b1;
			if (r.bit_cnt == '0)
			begin
				next_r.out_byte = r.phase == spi_cmd_pkg::PH_STATUS ? r.status : I_MEM_RDATA;
				next_r.so = r.phase == spi_cmd_pkg::PH_STATUS ? r.status[7] : I_MEM_RDATA[7];
			end
			else
			begin
				next_r.so = r.out_byte[3'd7 - r.bit_cnt];
			end
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			r <= '{sck_s: 2'h0, cs_s: 2'h3, si_s: 2'h0, hold_s: 2'h3, wp_s: 2'h3,
				sck_d: 1'b0, phase: spi_cmd_pkg::PH_OPCODE, shift: 8'h00, bit_cnt: 3'h0,
				addr_cnt: 5'h00, opcode: 8'h00, addr: 16'h0000, out_byte: 8'h00, so: 1'b0,
				so_oe: 1'b0, status: 8'h00, wrote: 1'b0, pend_write: 1'b0, timer: 32'h0,
				pu_timer: 32'(POWERUP_CYCLES), program_start: 1'b0};
		end
		else
		begin
			r <= next_r;
		end
	end

	// ************************************************************
	// write data buffer toward the array
	// ************************************************************
	// a full buffer drops the byte and no write cycle is started for it
	spi_cmd_fifo #(
		.WIDTH(26),
		.DEPTH(spi_cmd_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk(I_SYS_CLK),
		.i_reset_n(I_RESET_N),
		.i_valid(fifo_valid_in),
		.o_ready(fifo_ready),
		.i_data(fifo_in),
		.o_valid(O_MEM_REQ_VALID),
		.i_ready(I_MEM_REQ_READY),
		.o_data(fifo_out)
	);

	// ************************************************************
	// outputs
	// ************************************************************
	// the queue head owns the request lines; an empty queue shows the read in progress
	// a queued byte keeps its page, since the select bit clears when the frame ends
	assign O_MEM_REQ_WRITE = O_MEM_REQ_VALID && fifo_out[25];
	assign O_MEM_REQ_ID_PAGE = O_MEM_REQ_VALID ? fifo_out[24] : r.status[spi_cmd_pkg::ST_IDSEL];
	assign O_MEM_REQ_ADDR = O_MEM_REQ_VALID ? fifo_out[23:8] : r.addr;
	assign O_MEM_REQ_DATA = fifo_out[7:0];
	assign O_SO = r.so;
	// a pause parks the output off but keeps the enable, so it returns at once
	assign O_SO_OE = r.so_oe && active;
	assign O_PROGRAM_START = r.program_start;
	assign O_BUSY = r.status[spi_cmd_pkg::ST_BUSY];
	assign O_READY = r.pu_timer == '0;
	assign O_STATUS = r.status;
endmodule

// File: verification/spi_cmd_front_end_assertions.sv
// concurrent checks on the front end's ports, bound at its top
// *****
// checker
// *****
module spi_cmd_front_end_assertions #(
	parameter int WRITE_CYCLE_CYCLES = 2000,
	parameter int POWERUP_CYCLES = 400
) (
	input wire logic I_SYS_CLK,
	input wire logic I_RESET_N,
	input wire logic I_CS_N,
	input wire logic I_WP_N,
	input wire logic I_MEM_REQ_READY,
	input wire logic O_SO_OE,
	input wire logic O_MEM_REQ_VALID,
	input wire logic O_MEM_REQ_ID_PAGE,
	input wire logic [15:0] O_MEM_REQ_ADDR,
	input wire logic [7:0] O_MEM_REQ_DATA,
	input wire logic O_PROGRAM_START,
	input wire logic O_BUSY,
	input wire logic O_READY,
	input wire logic [7:0] O_STATUS
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] busy_cnt;
	logic [31:0] up_cnt;
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			busy_cnt <= '0;
			up_cnt <= '0;
		end
		else
		begin
			busy_cnt <= O_BUSY ? busy_cnt + 1 : '0;
			up_cnt <= up_cnt + 1;
		end
	end
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RESET_N);
	// select passes two sync flops, so allow four cycles
	a_oe_deselect: assert property (I_CS_N [*4] |-> !O_SO_OE) else $error("output on while idle");
	a_start_busy: assert property (O_PROGRAM_START |=> O_BUSY [*8]) else $error("busy missing");
	a_busy_span: assert property ($fell(O_BUSY) |-> busy_cnt >= WRITE_CYCLE_CYCLES - 1 &&
		busy_cnt <= WRITE_CYCLE_CYCLES + 1) else $error("write cycle length wrong");
	a_start_wel: assert property (O_PROGRAM_START |-> $past(O_STATUS[1])) else $error("program without latch");
	a_start_desel: assert property (O_PROGRAM_START |-> I_CS_N) else $error("program while selected");
	a_ready_time: assert property ($rose(O_READY) |-> up_cnt >= POWERUP_CYCLES &&
		up_cnt <= POWERUP_CYCLES + 6) else $error("ready at wrong time");
	a_req_hold: assert property (O_MEM_REQ_VALID && !I_MEM_REQ_READY |=> O_MEM_REQ_VALID &&
		$stable(O_MEM_REQ_ADDR) && $stable(O_MEM_REQ_DATA)) else $error("request dropped");
	a_id_page: assert property (!O_MEM_REQ_VALID |->
		O_MEM_REQ_ID_PAGE == O_STATUS[6]) else $error("page select mismatch");
	a_id_offset: assert property (O_MEM_REQ_VALID && O_MEM_REQ_ID_PAGE |->
		O_MEM_REQ_ADDR[15:7] == 9'h000) else $error("page offset out of range");
	a_wp_lock: assert property (!I_WP_N [*4] ##0 O_STATUS[7] |=> O_STATUS[7] &&
		$stable(O_STATUS[4:2])) else $error("locked status changed");
	c_start: cover property (O_PROGRAM_START);
	c_done: cover property ($fell(O_BUSY));
	c_pop: cover property (O_MEM_REQ_VALID && I_MEM_REQ_READY);
	c_id_req: cover property (O_MEM_REQ_VALID && O_MEM_REQ_ID_PAGE);
endmodule
bind spi_cmd_front_end spi_cmd_front_end_assertions #(
	.WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES),
	.POWERUP_CYCLES(POWERUP_CYCLES)
) u_spi_cmd_front_end_assertions (.*);

// File: verification/spi_host_model.sv
// serial host that frames commands toward the front end
// *****
// host
// *****
module spi_host_model (
	input wire logic i_clk,
	input wire logic i_so,
	output logic o_sck,
	output logic o_cs_n,
	output logic o_si,
	output logic o_hold_n
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
		o_hold_n = 1'b1;
	end
	// 1 ns off the falling edge keeps every pin change away from system edges
	task automatic xfer(input bit m3, input logic [39:0] tx, input int n, input int hold_at, output logic [39:0] rx);
		rx = '0;
		@(negedge i_clk);
		#1;
		// park the clock at its idle level first, so select never falls on a clock edge
		o_sck = m3;
		#62.5;
		o_cs_n = 1'b0;
		#62.5;
		for (int i = 0; i < n; i++)
		begin
			o_sck = 1'b0;
			o_si = tx[n-1-i];
			#62.5;
			if (i == hold_at)
			begin
				o_hold_n = 1'b0;
				#62.5;
				o_sck = 1'b1;
				#62.5;
				o_sck = 1'b0;
				o_si = ~o_si;
				#62.5;
				o_si = tx[n-1-i];
				o_hold_n = 1'b1;
				#62.5;
			end
			o_sck = 1'b1;
			rx = {rx[38:0], i_so};
			#62.5;
		end
		o_sck = m3;
		o_si = ~o_si;
		#62.5;
		o_cs_n = 1'b1;
		#250;
	endtask
endmodule

// File: verification/spi_cmd_front_end_tb_top.sv
// self-checking bench for the serial command front end
// *****
// bench
// *****
module spi_cmd_front_end_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, reset_n, sck, cs_n, si, hold_n, wp_n, mem_ready;
	logic so, so_oe, req_valid, req_write, req_id, busy, ready;
	logic [15:0] req_addr;
	logic [7:0] req_data, mem_rdata;
	logic [39:0] r;
	int failures;
	int cmp_count;
	wire so_pin = so_oe ? so : 1'bz;
	spi_cmd_front_end #(.WRITE_CYCLE_CYCLES(2000), .POWERUP_CYCLES(400)) u_spi_cmd_front_end (
		.I_SYS_CLK(clk), .I_RESET_N(reset_n), .I_SCK(sck), .I_CS_N(cs_n), .I_SI(si),
		.I_HOLD_N(hold_n), .I_WP_N(wp_n), .O_SO(so), .O_SO_OE(so_oe),
		.O_MEM_REQ_VALID(req_valid), .I_MEM_REQ_READY(mem_ready), .O_MEM_REQ_WRITE(req_write),
		.O_MEM_REQ_ID_PAGE(req_id), .O_MEM_REQ_ADDR(req_addr), .O_MEM_REQ_DATA(req_data),
		.I_MEM_RDATA(mem_rdata), .O_PROGRAM_START(), .O_BUSY(busy), .O_READY(ready), .O_STATUS());
	spi_host_model u_spi_host_model (.i_clk(clk), .i_so(so_pin), .o_sck(sck), .o_cs_n(cs_n), .o_si(si),
		.o_hold_n(hold_n));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cmd(input logic [39:0] tx, input int n);
		u_spi_host_model.xfer(1'b0, tx, n, -1, r);
	endtask
	task automatic stat(input bit m3, input logic [7:0] exp);
		u_spi_host_model.xfer(m3, 40'h0500, 16, -1, r);
		chk(r[7:0], exp);
	endtask
	task automatic idle();
		for (int k = 0; k < 3000 && busy !== 1'b0; k++)
			@(negedge clk);
		chk(busy, 1'b0);
	endtask
	task automatic t_power();
		cmd(40'h06, 8);
		for (int k = 0; k < 1000 && ready !== 1'b1; k++)
			@(negedge clk);
		chk(ready, 1'b1);
		stat(1'b0, 8'h00);
	endtask
	task automatic t_latch();
		cmd(40'h06, 8);
		stat(1'b1, 8'h02);
		cmd(40'h04, 8);
		stat(1'b0, 8'h00);
		cmd(40'h06, 8);
		u_spi_host_model.xfer(1'b0, 40'h85ff, 16, -1, r);
		chk(r[7:0], 8'hzz);
		stat(1'b0, 8'h02);
	endtask
	task automatic t_status();
		cmd(40'h01c4, 16);
		idle();
		stat(1'b0, 8'hc4);
		chk(req_id, 1'b1);
		@(negedge clk);
		wp_n = 1'b0;
		cmd(40'h06, 8);
		cmd(40'h0100, 16);
		idle();
		u_spi_host_model.xfer(1'b0, 40'h0500, 16, -1, r);
		chk(r[7:0] & 8'hfd, 8'hc4);
		@(negedge clk);
		wp_n = 1'b1;
		cmd(40'h06, 8);
		cmd(40'h0100, 16);
		idle();
		stat(1'b0, 8'h00);
	endtask
	task automatic t_write();
		cmd(40'h02107fa5, 32);
		chk(req_valid, 1'b0);
		cmd(40'h06, 8);
		cmd(40'h02107fa55a, 40);
		chk(busy, 1'b1);
		chk(req_write, 1'b1);
		chk(req_addr, 16'h107f);
		chk(req_data, 8'ha5);
		@(negedge clk);
		mem_ready = 1'b1;
		@(negedge clk);
		mem_ready = 1'b0;
		// the page offset wraps, upper address bits stay
		chk(req_addr, 16'h1000);
		chk(req_data, 8'h5a);
		@(negedge clk);
		mem_ready = 1'b1;
		@(negedge clk);
		chk(req_valid, 1'b0);
		stat(1'b0, 8'h03);
		cmd(40'h04, 8);
		stat(1'b0, 8'h03);
		idle();
		stat(1'b0, 8'h00);
		// a page byte keeps its page flag after the frame has cleared the select bit
		@(negedge clk);
		mem_ready = 1'b0;
		cmd(40'h06, 8);
		cmd(40'h0140, 16);
		cmd(40'h06, 8);
		cmd(40'h02ff85c3, 32);
		chk(req_id, 1'b1);
		chk(req_addr, 16'h0005);
		chk(req_data, 8'hc3);
		@(negedge clk);
		mem_ready = 1'b1;
		idle();
		stat(1'b0, 8'h00);
	endtask
	task automatic t_read();
		@(negedge clk);
		mem_rdata = 8'h96;
		u_spi_host_model.xfer(1'b1, 40'h03004000, 32, 27, r);
		chk(r[7:0], 8'h96);
		chk(so_oe, 1'b0);
	endtask
	initial
	begin
		failures = 0;
		cmp_count = 0;
		reset_n = 1'b0;
		wp_n = 1'b1;
		mem_ready = 1'b0;
		mem_rdata = 8'h00;
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		t_power();
		t_latch();
		t_status();
		t_write();
		t_read();
		report_and_stop();
	end
	// tests need about 110 us; allow several times that
	initial
	begin
		#800000;
		failures++;
		report_and_stop();
	end
endmodule
